//--- hdl/branch_exec_pkg.sv
package branch_exec_pkg;

  // Instruction cycle phases
  localparam logic [1:0]  PH_Q1           = 2'h0;
  localparam logic [1:0]  PH_Q2           = 2'h1;
  localparam logic [1:0]  PH_Q3           = 2'h2;
  localparam logic [1:0]  PH_Q4           = 2'h3;
  localparam int          PHASE_COUNT     = 4;

  // Opcode fields
  localparam logic [7:0]  OP_CARRY_CLEAR  = 8'he3;
  localparam logic [7:0]  OP_NOT_NEGATIVE = 8'he7;
  localparam logic [7:0]  OP_NO_OVERFLOW  = 8'he5;
  localparam logic [7:0]  OP_NONZERO      = 8'he1;
  localparam logic [4:0]  OP_JUMP         = 5'h1a;
  localparam logic [3:0]  OP_SET_BIT      = 4'h8;
  localparam int          OPC_HI          = 15;
  localparam int          BIT_SEL_LSB     = 9;
  localparam int          BANK_MODE_POS   = 8;
  localparam int          SHORT_OFS_W     = 8;
  localparam int          LONG_OFS_W      = 11;

  // Data memory geometry, program counter width and step
  localparam int          DATA_ADDR_W     = 12;
  localparam int          BANK_W          = 4;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h80;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hf;
  localparam int          PC_W            = 21;
  localparam logic [20:0] PC_STEP         = 21'h000002;

  // Register map, byte addresses
  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h4;
  localparam logic [3:0]  REG_TAKEN_CNT   = 4'h8;
  localparam logic [3:0]  REG_LAST_TARGET = 4'hc;
  localparam int          CTRL_EN_POS     = 0;
  localparam logic        CTRL_EN_RST     = 1'b1;
  localparam int          ST_BUSY_POS     = 0;
  localparam int          ST_TAKEN_POS    = 1;
  localparam int          ST_SETBIT_POS   = 2;
  localparam int          TAKEN_CNT_W     = 16;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_COND,
    KIND_JUMP,
    KIND_SETBIT
  } instr_kind_e;

endpackage

//--- hdl/q_phase_gen.sv
`timescale 1ns/10ps
module q_phase_gen
  import branch_exec_pkg::*;
#(
  parameter int PHASES = PHASE_COUNT
)(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  output logic [1:0]      phase_o,
  output logic            last_o
);

  initial
  begin
    if (PHASES != 4)
      $error("q_phase_gen supports exactly four phases");
  end

  logic [1:0] phase_q;

  // Free-running Q1..Q4 sequence, one phase per clock
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      phase_q <= PH_Q1;
    else
      phase_q <= phase_q + 2'h1;
  end

  assign phase_o = phase_q;
  assign last_o  = (phase_q == PH_Q4);

endmodule

//--- hdl/branch_and_bit_set_execution.sv
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module branch_and_bit_set_execution
  import branch_exec_pkg::*;
#(
  parameter int ADDR_W = DATA_ADDR_W
)(
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  // Instruction stream
  input  wire logic [15:0]            instr_i,
  input  wire logic                   instr_valid_i,
  input  wire logic [PC_W-1:0]        instr_addr_i,
  output logic                        busy_o,
  output logic [1:0]                  phase_o,
  // Status flags and bank select
  input  wire logic                   carry_i,
  input  wire logic                   negative_i,
  input  wire logic                   overflow_i,
  input  wire logic                   zero_i,
  input  wire logic [BANK_W-1:0]      bank_select_reg_i,
  // Program counter load
  output logic                        pc_load_o,
  output logic [PC_W-1:0]             pc_new_o,
  // Data memory
  output logic [ADDR_W-1:0]           mem_addr_o,
  output logic                        mem_rd_o,
  input  wire logic [7:0]             mem_rdata_i,
  output logic                        mem_wr_o,
  output logic [7:0]                  mem_wdata_o,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [3:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o
);

  initial
  begin
    if (ADDR_W != BANK_W + 8)
      $error("ADDR_W must equal bank width plus eight");
  end

  typedef enum logic {
    ST_RUN,
    ST_FLUSH
  } exec_state_e;

  logic              rst_meta_q;
  logic              rst_sync_q;
  logic [1:0]        phase;
  logic              phase_last;
  exec_state_e       state_q;
  instr_kind_e       kind_q;
  instr_kind_e       kind_d;
  logic [15:0]       instr_q;
  logic [PC_W-1:0]   pc_base_q;
  logic [PC_W-1:0]   target_q;
  logic              cond_ok;
  logic              taken_q;
  logic              ctrl_en_q;
  logic              last_taken_q;
  logic              last_setbit_q;
  logic [TAKEN_CNT_W-1:0] taken_cnt_q;
  logic [PC_W-1:0]   last_target_q;
  logic              pc_load_q;
  logic [PC_W-1:0]   pc_new_q;
  logic [ADDR_W-1:0] mem_addr_q;
  logic              mem_rd_q;
  logic              mem_wr_q;
  logic [7:0]        mem_wdata_q;
  logic              wb_ack_q;
  logic [31:0]       wb_dat_q;
  logic              wb_req;
  logic              wb_wr;

  // Sign-extended doubled offset of a given field width
  function automatic logic [PC_W-1:0] doubled_offset(input logic [10:0] field,
                                                     input logic        long_form);
    logic [PC_W-1:0] ext;
    ext = '0;
    if (long_form)
      ext = {{(PC_W-LONG_OFS_W){field[10]}}, field};
    else
      ext = {{(PC_W-SHORT_OFS_W){field[7]}}, field[7:0]};
    return {ext[PC_W-2:0], 1'b0};
  endfunction

  // File register address from bank mode, bank select and file field
  function automatic logic [ADDR_W-1:0] file_address(input logic            bank_mode,
                                                     input logic [BANK_W-1:0] bank,
                                                     input logic [7:0]      file);
    logic [BANK_W-1:0] hi;
    hi = '0;
    if (bank_mode)
      hi = bank;
    else if (file < ACCESS_SPLIT)
      hi = '0;
    else
      hi = ACCESS_HI_BANK;
    return {hi, file};
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  q_phase_gen #(
    .PHASES (PHASE_COUNT)
  ) u_phase (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_sync_q),
    .phase_o (phase),
    .last_o  (phase_last)
  );

  // Opcode decode
  always_comb
  begin
    kind_d = KIND_NONE;
    if (instr_i[OPC_HI -: 8] == OP_CARRY_CLEAR)
      kind_d = KIND_COND;
    else if (instr_i[OPC_HI -: 8] == OP_NOT_NEGATIVE)
      kind_d = KIND_COND;
    else if (instr_i[OPC_HI -: 8] == OP_NO_OVERFLOW)
      kind_d = KIND_COND;
    else if (instr_i[OPC_HI -: 8] == OP_NONZERO)
      kind_d = KIND_COND;
    else if (instr_i[OPC_HI -: 5] == OP_JUMP)
      kind_d = KIND_JUMP;
    else if (instr_i[OPC_HI -: 4] == OP_SET_BIT)
      kind_d = KIND_SETBIT;
  end

  // Branch condition from the flags, each branch on a clear flag
  always_comb
  begin
    case (instr_q[OPC_HI -: 8])
      OP_CARRY_CLEAR:  cond_ok = !carry_i;
      OP_NOT_NEGATIVE: cond_ok = !negative_i;
      OP_NO_OVERFLOW:  cond_ok = !overflow_i;
      OP_NONZERO:      cond_ok = !zero_i;
      default:         cond_ok = 1'b0;
    endcase
  end

  // Cycle state: a taken branch adds one idle cycle
  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      state_q <= ST_RUN;
    else if (phase_last)
    begin
      case (state_q)
        ST_RUN:   state_q <= taken_q ? ST_FLUSH : ST_RUN;
        ST_FLUSH: state_q <= ST_RUN;
        default:  state_q <= ST_RUN;
      endcase
    end
  end

  // Q1 decode: latch the instruction for this cycle
  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      kind_q    <= KIND_NONE;
      instr_q   <= '0;
      pc_base_q <= '0;
    end
    else if (phase == PH_Q1)
    begin
      if (state_q == ST_RUN && instr_valid_i && ctrl_en_q)
        kind_q <= kind_d;
      else
        kind_q <= KIND_NONE;
      instr_q   <= instr_i;
      pc_base_q <= instr_addr_i;
    end
  end

  // Q2 reads the offset and forms the target, Q3 makes the taken decision
  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      target_q <= '0;
      taken_q  <= 1'b0;
    end
    else
    begin
      if (phase == PH_Q2)
        target_q <= pc_base_q + PC_STEP
                    + doubled_offset(instr_q[10:0], kind_q == KIND_JUMP);
      if (phase == PH_Q3)
        taken_q <= (kind_q == KIND_JUMP) || (kind_q == KIND_COND && cond_ok);
      else if (phase_last)
        taken_q <= 1'b0;
    end
  end

  // Q4 program counter write
  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      pc_load_q <= 1'b0;
      pc_new_q  <= '0;
    end
    else if (phase == PH_Q3)
    begin
      pc_load_q <= (kind_q == KIND_JUMP) || (kind_q == KIND_COND && cond_ok);
      if ((kind_q == KIND_JUMP) || (kind_q == KIND_COND && cond_ok))
        pc_new_q <= target_q;
    end
    else
      pc_load_q <= 1'b0;
  end

  // Bit set: read in Q2, modify in Q3, write back in Q4
  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      mem_addr_q  <= '0;
      mem_rd_q    <= 1'b0;
      mem_wr_q    <= 1'b0;
      mem_wdata_q <= '0;
    end
    else
    begin
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      if (phase == PH_Q1 && state_q == ST_RUN && instr_valid_i && ctrl_en_q
          && kind_d == KIND_SETBIT)
      begin
        mem_addr_q <= file_address(instr_i[BANK_MODE_POS], bank_select_reg_i,
                                   instr_i[7:0]);
        mem_rd_q   <= 1'b1;
      end
      if (phase == PH_Q3 && kind_q == KIND_SETBIT)
      begin
        mem_wdata_q <= mem_rdata_i | (8'h01 << instr_q[BIT_SEL_LSB +: 3]);
        mem_wr_q    <= 1'b1;
      end
    end
  end

  // Status kept for software
  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      last_taken_q  <= 1'b0;
      last_setbit_q <= 1'b0;
      last_target_q <= '0;
    end
    else if (phase == PH_Q3 && kind_q != KIND_NONE)
    begin
      last_taken_q  <= (kind_q == KIND_JUMP) || (kind_q == KIND_COND && cond_ok);
      last_setbit_q <= (kind_q == KIND_SETBIT);
      if ((kind_q == KIND_JUMP) || (kind_q == KIND_COND && cond_ok))
        last_target_q <= target_q;
    end
  end

  // Taken branch counter; a count event beats a software clear
  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      taken_cnt_q <= '0;
    else if (phase == PH_Q3
             && ((kind_q == KIND_JUMP) || (kind_q == KIND_COND && cond_ok)))
      taken_cnt_q <= taken_cnt_q + 1'b1;
    else if (wb_wr && wb_adr_i == REG_TAKEN_CNT && wb_sel_i[0])
      taken_cnt_q <= '0;
  end

  // Wishbone slave: one wait state, ack for one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_q;
  assign wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_q;

  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      wb_ack_q <= 1'b0;
    else
      wb_ack_q <= wb_req;
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      ctrl_en_q <= CTRL_EN_RST;
    else if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0])
      ctrl_en_q <= wb_dat_i[CTRL_EN_POS];
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      wb_dat_q <= '0;
    else if (wb_req && !wb_we_i)
    begin
      wb_dat_q <= '0;
      case (wb_adr_i)
        REG_CTRL:
          wb_dat_q[CTRL_EN_POS] <= ctrl_en_q;
        REG_STATUS:
        begin
          wb_dat_q[ST_BUSY_POS]   <= (state_q == ST_FLUSH);
          wb_dat_q[ST_TAKEN_POS]  <= last_taken_q;
          wb_dat_q[ST_SETBIT_POS] <= last_setbit_q;
        end
        REG_TAKEN_CNT:
          wb_dat_q[TAKEN_CNT_W-1:0] <= taken_cnt_q;
        REG_LAST_TARGET:
          wb_dat_q[PC_W-1:0] <= last_target_q;
        default:
          wb_dat_q <= '0;
      endcase
    end
  end

  assign wb_ack_o    = wb_ack_q;
  assign wb_dat_o    = wb_dat_q;
  assign busy_o      = (state_q == ST_FLUSH);
  assign phase_o     = phase;
  assign pc_load_o   = pc_load_q;
  assign pc_new_o    = pc_new_q;
  assign mem_addr_o  = mem_addr_q;
  assign mem_rd_o    = mem_rd_q;
  assign mem_wr_o    = mem_wr_q;
  assign mem_wdata_o = mem_wdata_q;

endmodule

//--- testbench/branch_and_bit_set_execution_sva.sv
`timescale 1ns/10ps
module branch_and_bit_set_execution_sva
  import branch_exec_pkg::*;
(
  input wire logic            clk_sys_i,
  input wire logic            reset_n_i,
  input wire logic [1:0]      phase_o,
  input wire logic            busy_o,
  input wire logic            pc_load_o,
  input wire logic [PC_W-1:0] pc_new_o,
  input wire logic            mem_rd_o,
  input wire logic            mem_wr_o,
  input wire logic [7:0]      mem_rdata_i,
  input wire logic [7:0]      mem_wdata_o,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_read_in_q2: assert property (mem_rd_o |-> phase_o == PH_Q2)
    else $error("memory read outside Q2");
  a_write_in_q4: assert property (mem_wr_o |-> phase_o == PH_Q4)
    else $error("memory write outside Q4");
  a_pc_in_q4: assert property (pc_load_o |-> phase_o == PH_Q4)
    else $error("program counter load outside Q4");
  a_phase_steps: assert property (phase_o == PH_Q2 |=> phase_o == PH_Q3)
    else $error("phase did not advance");
  a_read_then_write: assert property (mem_rd_o |-> ##2 mem_wr_o)
    else $error("write did not follow read");
  a_wdata_one_bit: assert property (mem_wr_o |->
      ((mem_wdata_o & $past(mem_rdata_i)) == $past(mem_rdata_i))
      && ($countones(mem_wdata_o ^ $past(mem_rdata_i)) <= 1))
    else $error("write data is not read data with one bit set");
  a_idle_after_load: assert property (pc_load_o |=> busy_o [*4] ##1 !busy_o)
    else $error("idle cycle after branch not four clocks");
  a_idle_is_quiet: assert property (busy_o |-> !mem_rd_o && !mem_wr_o && !pc_load_o)
    else $error("activity during idle cycle");
  a_target_holds: assert property (pc_load_o |=> $stable(pc_new_o) [*4])
    else $error("target changed too early");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus acknowledge late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one clock");
  cover property (pc_load_o);
  cover property (mem_wr_o);
  cover property (wb_ack_o);
endmodule

//--- testbench/branch_and_bit_set_execution_tb.sv
`timescale 1ns/10ps
module branch_and_bit_set_execution_tb
  import branch_exec_pkg::*;
;
  logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, instr_valid_i = 1'b0;
  logic        carry_i = 1'b0, negative_i = 1'b0, overflow_i = 1'b0, zero_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [15:0] instr_i = 16'h0;
  logic [20:0] instr_addr_i = 21'h0;
  logic [3:0]  bank_select_reg_i = 4'h0, wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [7:0]  mem_rdata_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic        busy_o, pc_load_o, mem_rd_o, mem_wr_o, wb_ack_o;
  logic [1:0]  phase_o;
  logic [20:0] pc_new_o;
  logic [11:0] mem_addr_o, m;
  logic [7:0]  mem_wdata_o, f, r;
  logic [31:0] wb_dat_o, q;
  logic [15:0] w;
  logic [7:0]  ops [4] = '{OP_CARRY_CLEAR, OP_NOT_NEGATIVE, OP_NO_OVERFLOW, OP_NONZERO};
  int          bad_count = 0, cmp_count = 0, i;

  always #12.5 clk_sys_i = ~clk_sys_i;

  branch_and_bit_set_execution u_dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .instr_addr_i(instr_addr_i), .busy_o(busy_o),
    .phase_o(phase_o), .carry_i(carry_i), .negative_i(negative_i), .overflow_i(overflow_i),
    .zero_i(zero_i), .bank_select_reg_i(bank_select_reg_i), .pc_load_o(pc_load_o),
    .pc_new_o(pc_new_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
    .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  function automatic logic [20:0] tgt(input logic [20:0] a, input logic [10:0] o,
                                      input logic long_ofs);
    logic [20:0] s;
    s = long_ofs ? {{10{o[10]}}, o} : {{13{o[7]}}, o[7:0]};
    return a + 21'h2 + (s << 1);
  endfunction

  // Presents one instruction in Q1, then checks Q2 read, Q4 result and the idle cycle
  task automatic exec(input logic [15:0] wd_i, input logic [20:0] a, input logic [3:0] fl,
                      input logic [3:0] bs, input logic [7:0] rd, input logic ld,
                      input logic [20:0] t, input logic wr, input logic [11:0] ma,
                      input logic [7:0] wd);
    do @(posedge clk_sys_i); while (phase_o !== PH_Q4);
    instr_i <= wd_i;
    instr_valid_i <= 1'b1;
    instr_addr_i <= a;
    {carry_i, negative_i, overflow_i, zero_i} <= fl;
    bank_select_reg_i <= bs;
    mem_rdata_i <= rd;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
    #1 chk(32'(mem_rd_o), 32'(wr));
    repeat (2) @(posedge clk_sys_i);
    #1 chk(32'(pc_load_o), 32'(ld));
    chk(32'(mem_wr_o), 32'(wr));
    if (ld)
      chk(32'(pc_new_o), 32'(t));
    if (wr)
      chk({12'h0, mem_addr_o, mem_wdata_o}, {12'h0, ma, wd});
    if (ld)
    begin
      @(posedge clk_sys_i);
      #1 chk(32'(busy_o), 32'h1);
    end
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h1);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    for (i = 0; i < 4; i++)
    begin
      w = {ops[i], i[0] ? 8'h7f : 8'h80};
      exec(w, 21'h100, ~(4'h8 >> i), 4'h0, 8'h0, 1'b1, tgt(21'h100, w[10:0], 1'b0),
           1'b0, 12'h0, 8'h0);
      exec(w, 21'h200, 4'h8 >> i, 4'h0, 8'h0, 1'b0, 21'h0, 1'b0, 12'h0, 8'h0);
    end
    exec({OP_JUMP, 11'h400}, 21'h10, 4'hf, 4'h0, 8'h0, 1'b1,
         tgt(21'h10, 11'h400, 1'b1), 1'b0, 12'h0, 8'h0);
    exec({OP_JUMP, 11'h3ff}, 21'h1ffff0, 4'h0, 4'h0, 8'h0, 1'b1,
         tgt(21'h1ffff0, 11'h3ff, 1'b1), 1'b0, 12'h0, 8'h0);
    wb(1'b0, REG_TAKEN_CNT, 32'h0);
    chk(q, 32'h6);
    wb(1'b0, REG_LAST_TARGET, 32'h0);
    chk(q, 32'(tgt(21'h1ffff0, 11'h3ff, 1'b1)));
    for (i = 0; i < 8; i++)
    begin
      f = i[1] ? 8'h90 : 8'h10;
      r = 8'ha5 + 8'(i);
      m = i[0] ? {4'h5, f} : (f < ACCESS_SPLIT ? {4'h0, f} : {ACCESS_HI_BANK, f});
      exec({OP_SET_BIT, i[2:0], i[0], f}, 21'h40, 4'h0, 4'h5, r, 1'b0, 21'h0,
           1'b1, m, r | (8'h1 << i[2:0]));
    end
    wb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h4);
    wb(1'b1, REG_TAKEN_CNT, 32'h0);
    wb(1'b0, REG_TAKEN_CNT, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, REG_CTRL, 32'h0);
    exec({OP_JUMP, 11'h005}, 21'h80, 4'h0, 4'h0, 8'h0, 1'b0, 21'h0, 1'b0, 12'h0, 8'h0);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0);
    results();
  end
endmodule

bind branch_and_bit_set_execution branch_and_bit_set_execution_sva u_sva (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .phase_o(phase_o), .busy_o(busy_o),
  .pc_load_o(pc_load_o), .pc_new_o(pc_new_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .mem_rdata_i(mem_rdata_i), .mem_wdata_o(mem_wdata_o), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
